//--- pkg/dapo_pkg.sv
// constants, types and decode helpers for the disc audio output path
package dapo_pkg;
	// system clock
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;
	localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
	// level ramp: full scale to mute in 128 steps over 3 ms (at n = 1)
	localparam int unsigned RAMP_US = 3000;
	localparam int unsigned LEVEL_STEPS = 128;
	localparam int unsigned STEP_CYC = (RAMP_US * CLK_MHZ) / LEVEL_STEPS;
	// uncorrectable strobe low time, 140 us at n = 1
	localparam int unsigned STROBE_NS = 140000;
	localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// flag word serial bit time, 8 bits fit easily in one frame
	localparam int unsigned FLAG_BIT_NS = 5000;
	localparam int unsigned FLAG_BIT_CYC = (FLAG_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned FLAG_BITS = 8;
	// serial bit clock rates at n = 1
	localparam longint unsigned SCLK_1FS_HZ = 2116800;
	localparam longint unsigned SCLK_2FS_HZ = 4233600;
	localparam longint unsigned SCLK_4FS_HZ = 8467200;
	localparam int unsigned NCO_BITS = 24;
	// 48 bit slots per sample pair, 24 per channel
	localparam int unsigned SLOT_BITS = 24;
	localparam logic [5:0] PAIR_LAST = 6'h2F;
	// level counter points
	localparam logic [7:0] LVL_FULL = 8'h80;
	localparam logic [7:0] LVL_OS_SCALE = 8'h78;
	localparam logic [7:0] LVL_ATTEN = 8'h20;
	localparam logic [7:0] LVL_MUTE = 8'h00;
	// level commands
	localparam logic [1:0] CMD_FULL = 2'h0;
	localparam logic [1:0] CMD_MUTE = 2'h1;
	localparam logic [1:0] CMD_ATTEN = 2'h2;
	localparam logic [1:0] CMD_FADE = 2'h3;
	// register byte offsets
	localparam logic [3:0] REG_LEVEL = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_PEAK = 4'hC;
	// level register fields
	localparam int unsigned LEVEL_CMD_LSB = 0;
	localparam int unsigned LEVEL_FADE_LSB = 8;
	// control register fields
	localparam int unsigned CTRL_FMT_LSB = 0;
	localparam int unsigned CTRL_WSINV_BIT = 4;
	localparam int unsigned CTRL_DINV_BIT = 5;
	localparam int unsigned CTRL_DEROUTE_BIT = 6;
	localparam int unsigned CTRL_LOCK_BIT = 7;
	// status register fields
	localparam int unsigned STAT_LVL_LSB = 0;
	localparam int unsigned STAT_DEEMPH_BIT = 8;
	localparam int unsigned STAT_RAMP_BIT = 9;
	// reset values
	localparam logic [3:0] FMT_RESET = 4'hE;
	localparam logic [7:0] LVL_RESET = 8'h00;
	// peak bits inside the q-channel word
	localparam int unsigned Q_PEAK_LEFT_LSB = 81;
	localparam int unsigned Q_PEAK_RIGHT_MSB = 96;
	// dac format codes
	localparam logic [3:0] FMT_ROM_I2S = 4'hA;
	localparam logic [3:0] FMT_ROM_EIAJ = 4'hB;
	localparam logic [3:0] FMT_I2S_1FS = 4'hE;
	localparam logic [3:0] FMT_EIAJ16_1FS = 4'h2;
	localparam logic [3:0] FMT_EIAJ18_1FS = 4'h6;
	localparam logic [3:0] FMT_EIAJ16_4FS = 4'h0;
	localparam logic [3:0] FMT_EIAJ18_4FS = 4'h4;
	localparam logic [3:0] FMT_I2S_4FS = 4'hC;
	localparam logic [3:0] FMT_EIAJ16_2FS = 4'h3;
	localparam logic [3:0] FMT_EIAJ18_2FS = 4'h7;
	localparam logic [3:0] FMT_I2S_2FS = 4'hF;

	// decoded format
	typedef struct packed {
		logic [1:0] rate; // 0 = 1fs, 1 = 2fs, 2 = 4fs
		logic i2s; // left justified with one bit delay
		logic bits18; // 18 bit word
		logic flex; // 16 bits unless level or de-emphasis in use
		logic cdrom; // no concealment
	} dapo_fmt_t;

	// map a format code onto its properties, unknown codes act as cd-rom i2s
	function automatic dapo_fmt_t dapo_decode(input logic [3:0] code);
		dapo_fmt_t f;
		f = '{rate: 2'h0, i2s: 1'b1, bits18: 1'b0, flex: 1'b0, cdrom: 1'b1};
		case (code)
			FMT_ROM_EIAJ: f = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1};
			FMT_I2S_1FS: f = '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0};
			FMT_EIAJ16_1FS: f = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0};
			FMT_EIAJ18_1FS: f = '{2'h0, 1'b0, 1'b1, 1'b0, 1'b0};
			FMT_EIAJ16_4FS: f = '{2'h2, 1'b0, 1'b0, 1'b0, 1'b0};
			FMT_EIAJ18_4FS: f = '{2'h2, 1'b0, 1'b1, 1'b0, 1'b0};
			FMT_I2S_4FS: f = '{2'h2, 1'b1, 1'b1, 1'b0, 1'b0};
			FMT_EIAJ16_2FS: f = '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0};
			FMT_EIAJ18_2FS: f = '{2'h1, 1'b0, 1'b1, 1'b0, 1'b0};
			FMT_I2S_2FS: f = '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0};
			default: f = '{2'h0, 1'b1, 1'b0, 1'b0, 1'b1};
		endcase
		return f;
	endfunction
endpackage

//--- core/dapo_audio_out.sv
// audio back end: flag word, fail strobe, concealment, level, peaks and dac serialiser
// What this block does
// - first flag bit reports absolute time sync
// - two flag bits encode c1 frame result
// - three flag bits encode c2 frame result
// - two flag bits report holds and interpolations
// - fail strobe low 140/n us per event
// - de-emphasis inserted when q-channel signals pre-emphasis
// - de-emphasis bypassed when routed to spare pin
// - oversampling formats scale level down 0.5 dB
// - single bad sample becomes neighbour midpoint
// - bad runs hold, then interpolate last one
// - no concealment in cd-rom formats
// - mute ramps to zero in 128 steps
// - full scale ramps back to 0 dB
// - 128 stage level counter, fixed points
// - per channel peak of positive samples, 8 bits
// - peaks replace crc bits 81 to 96
// - peaks cleared after q-channel read out
// - msb first, word select and data invertible
// - four bit code selects eleven formats
// - bit clock rate per format, disc locked
// - flexible i2s sends 16 or 18 bits
// - error flag line defined in cd-rom, 1fs
// - flag word updated once per frame
//
// Local design decisions: the strobed register port and the register addresses.
module dapo_audio_out #(
	parameter int unsigned SPEED_N = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	// samples from the error corrector
	input wire logic sampleValid,
	input wire logic [15:0] sampleLeft,
	input wire logic [15:0] sampleRight,
	input wire logic sampleBadLeft,
	input wire logic sampleBadRight,
	// per-frame corrector status
	input wire logic frameTick,
	input wire logic timeSync,
	input wire logic [1:0] c1Result,
	input wire logic [2:0] c2Result,
	input wire logic c2FailEvent,
	// subcode side
	input wire logic preEmphasis,
	input wire logic qReadDone,
	output logic [15:0] qPeakField,
	// disc-locked bit clock reference
	input wire logic discClk,
	// dac interface
	output logic serialBitClock,
	output logic wordSelectClock,
	output logic serialData,
	output logic errorFlagLine,
	// status pins
	output logic uncorrectableBlockStrobeN,
	output logic corrFlagOut,
	output logic corrFlagOe,
	output logic sparePinFive
);
	// derived counts for the speed factor
	localparam int unsigned STEP_N = dapo_pkg::STEP_CYC / SPEED_N;
	localparam int unsigned STROBE_N = (dapo_pkg::STROBE_CYC + SPEED_N - 1) / SPEED_N;
	localparam logic [8:0] STEP_LAST = 9'(STEP_N - 1);
	localparam logic [11:0] STROBE_LOAD = 12'(STROBE_N);
	localparam logic [6:0] FLAG_LAST = 7'(dapo_pkg::FLAG_BIT_CYC - 1);
	// nco increments, one overflow per bit clock half period
	localparam longint unsigned NCO_ONE = longint'(1) << dapo_pkg::NCO_BITS;
	localparam logic [23:0] INC_1FS =
		24'((2 * dapo_pkg::SCLK_1FS_HZ * SPEED_N * NCO_ONE) / dapo_pkg::CLK_HZ);
	localparam logic [23:0] INC_2FS =
		24'((2 * dapo_pkg::SCLK_2FS_HZ * SPEED_N * NCO_ONE) / dapo_pkg::CLK_HZ);
	localparam logic [23:0] INC_4FS =
		24'((2 * dapo_pkg::SCLK_4FS_HZ * SPEED_N * NCO_ONE) / dapo_pkg::CLK_HZ);

	// whole state of the block
	typedef struct packed {
		logic [2:0] dsync; // disc clock synchroniser, bit 0 first stage
		logic discLvl; // agreed disc clock level
		logic [1:0] cmd; // last level command
		logic [7:0] fadeTgt; // fade target level
		logic [7:0] lvl; // level counter 0..128
		logic [8:0] stepCnt; // ramp step timer
		logic [3:0] fmt; // dac format code
		logic wsInv; // invert word select
		logic dataInv; // invert data
		logic deRoute; // de-emphasis shown on spare pin
		logic lockDisc; // bit clock follows disc
		logic pendValid; // a look-ahead sample is waiting
		logic [1:0][15:0] pend; // look-ahead sample per channel
		logic [1:0] pendBad; // its flag
		logic [1:0][15:0] last; // last concealed output
		logic [1:0][17:0] emph; // de-emphasis section state
		logic [1:0][17:0] outS; // processed sample
		logic [1:0] outBad; // flag of processed sample
		logic holdSeen; // frame saw a hold
		logic interpSeen; // frame saw an interpolation
		logic [1:0][7:0] peak; // per channel peak
		logic [11:0] strobeCnt; // fail strobe timer
		logic [7:0] flagSh; // flag word shifter
		logic [3:0] flagLeft; // bits still to send
		logic [6:0] flagCyc; // bit time counter
		logic [24:0] acc; // bit clock nco
		logic sclk; // bit clock
		logic [5:0] bitCnt; // slot in the sample pair
		logic [1:0][17:0] txS; // pair being sent
		logic [1:0] txBad; // its flags
		logic ws; // word select out
		logic sdata; // data out
		logic ef; // error flag out
		logic strobeN; // fail strobe out
		logic cfOe; // flag pin pulls low
		logic spare; // spare pin out
		logic [15:0] rdata; // read data
	} dapo_state_t;

	dapo_state_t q, d;

	// midpoint of two samples, sum kept one bit wider
	function automatic logic [15:0] dapo_mid(input logic [15:0] a, input logic [15:0] b);
		logic signed [16:0] s;
		s = 17'($signed(a)) + 17'($signed(b));
		return s[16:1];
	endfunction

	// scale an 18 bit sample by level/128
	function automatic logic [17:0] dapo_gain(input logic [17:0] x, input logic [7:0] g);
		logic signed [26:0] p;
		p = 27'($signed(x)) * 27'($signed({1'b0, g}));
		return p[24:7];
	endfunction

	// next state
	always_comb begin
		dapo_pkg::dapo_fmt_t f;
		logic [7:0] tgt;
		logic [7:0] effLvl;
		logic deActive;
		logic discEdge;
		logic tick;
		logic [1:0] nb;
		logic [1:0][15:0] nw;
		logic [15:0] c;
		logic bad;
		logic [17:0] y;
		logic [4:0] wlen;
		logic [4:0] p;
		logic [4:0] k;
		logic chan;
		logic bitv;
		logic [23:0] inc;
		f = dapo_pkg::dapo_decode(q.fmt);
		d = q;
		nb = {sampleBadRight, sampleBadLeft};
		nw = {sampleRight, sampleLeft};
		c = 16'h0000;
		bad = 1'b0;
		y = 18'h00000;
		k = 5'h00;
		bitv = 1'b0;
		wlen = 5'd16;
		p = 5'h00;
		chan = 1'b0;

		// disc clock: three stages, a change counts once stages two and three agree
		d.dsync = {q.dsync[1:0], discClk};
		discEdge = (q.dsync[1] == q.dsync[2]) && (q.dsync[2] != q.discLvl);
		if (discEdge) begin
			d.discLvl = q.dsync[2];
		end

		// register writes
		if (regWr) begin
			case (regAddr)
				dapo_pkg::REG_LEVEL: begin
					d.cmd = regWrData[dapo_pkg::LEVEL_CMD_LSB +: 2];
					d.fadeTgt = regWrData[dapo_pkg::LEVEL_FADE_LSB +: 8];
				end
				dapo_pkg::REG_CTRL: begin
					d.fmt = regWrData[dapo_pkg::CTRL_FMT_LSB +: 4];
					d.wsInv = regWrData[dapo_pkg::CTRL_WSINV_BIT];
					d.dataInv = regWrData[dapo_pkg::CTRL_DINV_BIT];
					d.deRoute = regWrData[dapo_pkg::CTRL_DEROUTE_BIT];
					d.lockDisc = regWrData[dapo_pkg::CTRL_LOCK_BIT];
				end
				default: begin
					// read-only or unmapped, write ignored
				end
			endcase
		end

		// level target from the command
		case (q.cmd)
			dapo_pkg::CMD_MUTE: tgt = dapo_pkg::LVL_MUTE;
			dapo_pkg::CMD_ATTEN: tgt = dapo_pkg::LVL_ATTEN;
			dapo_pkg::CMD_FADE: tgt = (q.fadeTgt > dapo_pkg::LVL_FULL) ?
				dapo_pkg::LVL_FULL : q.fadeTgt;
			default: tgt = dapo_pkg::LVL_FULL;
		endcase

		// level ramp: one step of the counter per step time
		if (q.lvl == tgt) begin
			d.stepCnt = 9'h000;
		end else if (q.stepCnt == STEP_LAST) begin
			d.stepCnt = 9'h000;
			d.lvl = (q.lvl < tgt) ? q.lvl + 8'h01 : q.lvl - 8'h01;
		end else begin
			d.stepCnt = q.stepCnt + 9'h001;
		end

		// oversampling formats run at 120/128 of the counter
		effLvl = q.lvl;
		if (f.rate != 2'h0) begin
			effLvl = 8'((16'(q.lvl) * 16'(dapo_pkg::LVL_OS_SCALE)) >> 7);
		end
		deActive = preEmphasis && !q.deRoute;
		d.spare = preEmphasis && q.deRoute;

		// sample path, one sample of look-ahead for interpolation
		if (sampleValid) begin
			d.pend = nw;
			d.pendBad = nb;
			d.pendValid = 1'b1;
			if (q.pendValid) begin
				for (int ch = 0; ch < 2; ch++) begin
					bad = q.pendBad[ch] && !f.cdrom;
					if (!bad) begin
						c = q.pend[ch];
					end else if (!nb[ch]) begin
						// single bad or last of a run: midpoint to the next good
						c = dapo_mid(q.last[ch], nw[ch]);
						d.interpSeen = 1'b1;
					end else begin
						// run continues: hold
						c = q.last[ch];
						d.holdSeen = 1'b1;
					end
					d.last[ch] = c;
					// de-emphasis section or straight path
					if (deActive) begin
						// one bit of headroom so the difference cannot wrap
						y = 18'(19'($signed(q.emph[ch])) + ((19'($signed({c, 2'b00}))
							- 19'($signed(q.emph[ch]))) >>> 1));
					end else begin
						y = {c, 2'b00};
					end
					d.emph[ch] = y;
					d.outS[ch] = dapo_gain(y, effLvl);
					d.outBad[ch] = q.pendBad[ch];
					// peak of positive values, top 8 magnitude bits
					if (!d.outS[ch][17] && (d.outS[ch][16:9] > q.peak[ch])) begin
						d.peak[ch] = d.outS[ch][16:9];
					end
				end
			end
		end

		// peaks restart after the q-channel has been read; a new peak still lands
		if (qReadDone) begin
			for (int ch = 0; ch < 2; ch++) begin
				d.peak[ch] = 8'h00;
				if (sampleValid && q.pendValid && !d.outS[ch][17]) begin
					d.peak[ch] = d.outS[ch][16:9];
				end
			end
		end

		// fail strobe, retriggered by every event
		if (c2FailEvent) begin
			d.strobeCnt = STROBE_LOAD;
		end else if (q.strobeCnt != 12'h000) begin
			d.strobeCnt = q.strobeCnt - 12'h001;
		end
		d.strobeN = (d.strobeCnt == 12'h000);

		// flag word: captured each frame, sent first bit first, open drain
		if (frameTick) begin
			d.flagSh = {timeSync, c1Result, c2Result[2:1], d.holdSeen, d.interpSeen,
				c2Result[0]};
			d.flagLeft = 4'(dapo_pkg::FLAG_BITS);
			d.flagCyc = 7'h00;
			// events of this cycle were just captured
			d.holdSeen = 1'b0;
			d.interpSeen = 1'b0;
		end else if (q.flagLeft != 4'h0) begin
			if (q.flagCyc == FLAG_LAST) begin
				d.flagCyc = 7'h00;
				d.flagSh = {q.flagSh[6:0], 1'b1};
				d.flagLeft = q.flagLeft - 4'h1;
			end else begin
				d.flagCyc = q.flagCyc + 7'h01;
			end
		end
		d.cfOe = (d.flagLeft != 4'h0) && !d.flagSh[7];

		// bit clock: nco at the format rate, or the disc clock
		case (f.rate)
			2'h1: inc = INC_2FS;
			2'h2: inc = INC_4FS;
			default: inc = INC_1FS;
		endcase
		d.acc = {1'b0, q.acc[23:0]} + {1'b0, inc};
		tick = q.lockDisc ? discEdge : d.acc[24];
		if (tick) begin
			d.sclk = !q.sclk;
		end

		// serialiser moves on each falling bit clock edge
		if (tick && q.sclk) begin
			d.bitCnt = (q.bitCnt == dapo_pkg::PAIR_LAST) ? 6'h00 : q.bitCnt + 6'h01;
			if (d.bitCnt == 6'h00) begin
				d.txS = q.outS;
				d.txBad = q.outBad;
			end
			chan = (d.bitCnt >= 6'(dapo_pkg::SLOT_BITS));
			p = chan ? 5'(d.bitCnt - 6'(dapo_pkg::SLOT_BITS)) : 5'(d.bitCnt);
			// word length of the current format
			if (f.bits18 || (f.flex && (q.cmd != dapo_pkg::CMD_FULL || deActive))) begin
				wlen = 5'd18;
			end else begin
				wlen = 5'd16;
			end
			// position of the msb: one slot in for i2s, right justified otherwise
			if (f.i2s) begin
				if (p >= 5'd1 && p <= wlen) begin
					k = p - 5'd1;
					bitv = 1'b1;
				end
			end else if (p >= 5'(dapo_pkg::SLOT_BITS) - wlen) begin
				k = p - (5'(dapo_pkg::SLOT_BITS) - wlen);
				bitv = 1'b1;
			end
			d.sdata = (bitv ? d.txS[chan][5'd17 - k] : 1'b0) ^ q.dataInv;
			d.ws = (f.i2s ? chan : !chan) ^ q.wsInv;
			d.ef = (f.cdrom || f.rate == 2'h0) ? d.txBad[chan] : 1'b0;
		end

		// register reads, answered one cycle later
		d.rdata = 16'h0000;
		if (regRd) begin
			case (regAddr)
				dapo_pkg::REG_LEVEL: d.rdata = {q.fadeTgt, 6'h00, q.cmd};
				dapo_pkg::REG_CTRL: d.rdata = {8'h00, q.lockDisc, q.deRoute, q.dataInv,
					q.wsInv, q.fmt};
				dapo_pkg::REG_STATUS: d.rdata = {6'h00, (q.lvl != tgt), deActive, q.lvl};
				dapo_pkg::REG_PEAK: d.rdata = {q.peak[1], q.peak[0]};
				default: d.rdata = 16'h0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.lvl <= dapo_pkg::LVL_RESET;
			q.cmd <= dapo_pkg::CMD_MUTE;
			q.fmt <= dapo_pkg::FMT_RESET;
			q.strobeN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state, corrFlagOut tied low
	assign regRdData = q.rdata;
	assign qPeakField = {q.peak[1], q.peak[0]};
	assign serialBitClock = q.sclk;
	assign wordSelectClock = q.ws;
	assign serialData = q.sdata;
	assign errorFlagLine = q.ef;
	assign uncorrectableBlockStrobeN = q.strobeN;
	assign corrFlagOut = 1'b0;
	assign corrFlagOe = q.cfOe;
	assign sparePinFive = q.spare;
endmodule // dapo_audio_out

//--- dv/dapo_out_monitor.sv
// checker for the audio output path ports
module dapo_out_monitor #(
	parameter int unsigned SPEED_N = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// frame status and events
	input wire logic frameTick,
	input wire logic timeSync,
	input wire logic [1:0] c1Result,
	input wire logic [2:0] c2Result,
	input wire logic c2FailEvent,
	input wire logic corrFlagOe,
	input wire logic uncorrectableBlockStrobeN,
	// peaks
	input wire logic sampleValid,
	input wire logic qReadDone,
	input wire logic [15:0] qPeakField,
	// dac lines
	input wire logic serialBitClock,
	input wire logic serialData
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [15:0] lowCnt_q; // cycles the fail strobe has been low
	logic [15:0] age_q; // cycles since the last frame tick, saturates
	logic [7:0] cap_q; // flag word expected, hold and interp left 0
	// helper counters and captured frame status
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lowCnt_q <= 16'h0000;
			age_q <= 16'hFFFF;
			cap_q <= 8'h00;
		end else begin
			lowCnt_q <= uncorrectableBlockStrobeN ? 16'h0000 : lowCnt_q + 16'h0001;
			if (frameTick) begin
				age_q <= 16'h0001;
				cap_q <= {timeSync, c1Result, c2Result[2:1], 2'b00, c2Result[0]};
			end else if (age_q != 16'hFFFF) begin
				age_q <= age_q + 16'h0001;
			end
		end
	end
	a_flag_sync: assert property (age_q == 16'd1 |-> corrFlagOe == !cap_q[7])
		else $error("flag word first bit wrong");
	a_flag_c1: assert property (age_q == 16'd150 |-> corrFlagOe == !cap_q[6])
		else $error("flag word c1 bit wrong");
	a_flag_c2: assert property (age_q == 16'd750 |-> corrFlagOe == !cap_q[0])
		else $error("flag word c2 low bit wrong");
	a_flag_end: assert property (age_q == 16'd801 |-> !corrFlagOe)
		else $error("flag word not released");
	a_strobe_go: assert property (c2FailEvent |=> !uncorrectableBlockStrobeN)
		else $error("fail strobe did not start");
	a_strobe_len: assert property ($rose(uncorrectableBlockStrobeN) |->
		lowCnt_q >= dapo_pkg::STROBE_CYC / SPEED_N) else $error("fail strobe too short");
	a_peak_clear: assert property (qReadDone && !sampleValid |->
		##[1:2] qPeakField == 16'h0000) else $error("peaks not cleared");
	a_peak_grow: assert property (!qReadDone && !$past(qReadDone) |=>
		qPeakField[7:0] >= $past(qPeakField[7:0]) && qPeakField[15:8] >= $past(qPeakField[15:8]))
		else $error("peak fell without clear");
	a_data_edge: assert property ($changed(serialData) |-> $fell(serialBitClock))
		else $error("data moved off falling bit clock");
	a_bclk_half: assert property ($changed(serialBitClock) |=>
		$stable(serialBitClock) [*3] ##[1:2] $changed(serialBitClock))
		else $error("bit clock half period wrong");
endmodule // dapo_out_monitor

bind dapo_audio_out dapo_out_monitor #(.SPEED_N(SPEED_N)) i_dapo_out_monitor (
	.clk_sys(clk_sys), .nrst(nrst), .frameTick(frameTick), .timeSync(timeSync),
	.c1Result(c1Result), .c2Result(c2Result), .c2FailEvent(c2FailEvent),
	.corrFlagOe(corrFlagOe), .uncorrectableBlockStrobeN(uncorrectableBlockStrobeN),
	.sampleValid(sampleValid), .qReadDone(qReadDone), .qPeakField(qPeakField),
	.serialBitClock(serialBitClock), .serialData(serialData));

//--- dv/dapo_dac_model.sv
// external dac model: counts bit clocks per channel, keeps the left word
module dapo_dac_model (
	// dac lines
	input wire logic serialBitClock,
	input wire logic wordSelectClock,
	input wire logic serialData,
	// observation
	output logic [5:0] slotCnt,
	output logic [23:0] leftWord
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] runCnt = 6'h00; // bit clocks in the current channel
	logic [23:0] shiftReg = 24'h000000; // bits in arrival order
	logic wsPrev = 1'b0; // word select at the previous bit clock
	initial slotCnt = 6'h00;
	initial leftWord = 24'h000000;
	// dac samples data and word select on the rising bit clock
	always @(posedge serialBitClock) begin
		shiftReg <= {shiftReg[22:0], serialData};
		wsPrev <= wordSelectClock;
		if (wordSelectClock != wsPrev) begin
			// a new channel starts, the one before is closed
			slotCnt <= runCnt;
			runCnt <= 6'h01;
			if (wordSelectClock) begin
				// left channel ends where word select rises
				leftWord <= shiftReg;
			end
		end else begin
			runCnt <= runCnt + 6'h01;
		end
	end
endmodule // dapo_dac_model

//--- dv/tb.sv
// testbench for the disc audio output path
module tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
	// stimulus
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic sampleValid = 1'b0;
	logic [15:0] sampleLeft = 16'h0000;
	logic [15:0] sampleRight = 16'h0000;
	logic frameTick = 1'b0;
	logic timeSync = 1'b0;
	logic [1:0] c1Result = 2'h0;
	logic [2:0] c2Result = 3'h0;
	logic c2FailEvent = 1'b0;
	logic preEmphasis = 1'b0;
	logic qReadDone = 1'b0;
	logic discClk = 1'b0;
	logic sampleBadLeft = 1'b0;
	logic sampleBadRight = 1'b0;
	// observed
	logic [15:0] regRdData;
	logic [15:0] qPeakField;
	logic serialBitClock;
	logic wordSelectClock;
	logic serialData;
	logic strobeN;
	logic corrFlagOe;
	logic sparePinFive;
	logic errFlag;
	logic corrFlagOut;
	logic [5:0] slotCnt;
	logic [23:0] leftWord;
	logic [15:0] d; // last read value
	int err_total = 0;
	int tests_run = 0;
	// clocks: system 50 ns, disc reference 400 ns
	always #25 clk_sys = ~clk_sys;
	always #200 discClk = ~discClk;
	dapo_audio_out i_dapo_audio_out (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.sampleValid(sampleValid), .sampleLeft(sampleLeft), .sampleRight(sampleRight),
		.sampleBadLeft(sampleBadLeft), .sampleBadRight(sampleBadRight),
		.frameTick(frameTick),
		.timeSync(timeSync), .c1Result(c1Result), .c2Result(c2Result),
		.c2FailEvent(c2FailEvent), .preEmphasis(preEmphasis), .qReadDone(qReadDone),
		.qPeakField(qPeakField), .discClk(discClk), .serialBitClock(serialBitClock),
		.wordSelectClock(wordSelectClock), .serialData(serialData), .errorFlagLine(errFlag),
		.uncorrectableBlockStrobeN(strobeN), .corrFlagOut(corrFlagOut),
		.corrFlagOe(corrFlagOe),
		.sparePinFive(sparePinFive));
	dapo_dac_model i_dapo_dac_model (.serialBitClock(serialBitClock),
		.wordSelectClock(wordSelectClock), .serialData(serialData),
		.slotCnt(slotCnt), .leftWord(leftWord));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// register write, one strobe cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// register read, data taken in the following cycle
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	// one sample pair with bad flags (bit 0 left), then a gap
	task automatic pair(input logic [15:0] l, input logic [15:0] r, input logic [1:0] b = 2'b00);
		@(posedge clk_sys);
		sampleLeft <= l;
		sampleRight <= r;
		sampleBadLeft <= b[0];
		sampleBadRight <= b[1];
		sampleValid <= 1'b1;
		@(posedge clk_sys);
		sampleValid <= 1'b0;
		tick(20);
	endtask
	// reset values, read-only and unmapped places
	task automatic t_reset();
		rd(dapo_pkg::REG_CTRL);
		`CHK(d, {12'h000, dapo_pkg::FMT_RESET})
		wr(dapo_pkg::REG_STATUS, 16'hFFFF);
		rd(dapo_pkg::REG_STATUS);
		`CHK(d[7:0], dapo_pkg::LVL_RESET)
		rd(4'h1);
		`CHK(d, 16'h0000)
		`CHK(strobeN, 1'b1)
		`CHK(corrFlagOut, 1'b0)
		$display("reset test done");
	endtask
	// flag word for every c1 code and six of the eight c2 codes
	task automatic t_flag();
		logic [5:0] tbl [6];
		logic [7:0] w;
		tbl = '{6'h13, 6'h0C, 6'h3F, 6'h00, 6'h21, 6'h0A};
		for (int f = 0; f < 6; f++) begin
			@(posedge clk_sys);
			{timeSync, c1Result, c2Result} <= tbl[f];
			frameTick <= 1'b1;
			@(posedge clk_sys);
			frameTick <= 1'b0;
			w = {tbl[f][5:1], 2'b00, tbl[f][0]};
			tick(50);
			for (int i = 0; i < 8; i++) begin
				#1 `CHK(corrFlagOe, ~w[7 - i])
				tick(100);
			end
			#1 `CHK(corrFlagOe, 1'b0)
		end
		$display("flag test done");
	endtask
	// fail strobe length
	task automatic t_strobe();
		@(posedge clk_sys);
		c2FailEvent <= 1'b1;
		@(posedge clk_sys);
		c2FailEvent <= 1'b0;
		tick(1);
		#1 `CHK(strobeN, 1'b0)
		tick(2798);
		#1 `CHK(strobeN, 1'b0)
		tick(1);
		#1 `CHK(strobeN, 1'b1)
		$display("strobe test done");
	endtask
	// full scale ramp from mute, dac framing
	task automatic t_level();
		wr(dapo_pkg::REG_LEVEL, {14'h0000, dapo_pkg::CMD_FULL});
		tick(128 * dapo_pkg::STEP_CYC + 100);
		rd(dapo_pkg::REG_STATUS);
		`CHK(d, {8'h00, dapo_pkg::LVL_FULL})
		`CHK(slotCnt, 6'd24)
		$display("level test done");
	endtask
	// peaks, clear, positive only, serial word
	task automatic t_peak();
		pair(16'h4000, 16'h2000);
		pair(16'h4000, 16'h2000);
		`CHK(qPeakField, 16'h4080)
		pair(16'hC000, 16'hC000);
		@(posedge clk_sys);
		qReadDone <= 1'b1;
		@(posedge clk_sys);
		qReadDone <= 1'b0;
		pair(16'hC000, 16'hC000);
		`CHK(qPeakField, 16'h0000)
		tick(1000);
		`CHK(leftWord[22:7], 16'hC000)
		$display("peak test done");
	endtask
	// concealment, its flag bits, error flag line, none in cd-rom format
	task automatic t_conceal();
		pair(16'h1000, 16'h0800);
		pair(16'h7000, 16'h7000, 2'b11);
		pair(16'h3000, 16'h7000, 2'b10);
		tick(1000);
		`CHK(leftWord[22:7], 16'h2000)
		`CHK(qPeakField, 16'h1040)
		`CHK(errFlag, 1'b1)
		pair(16'h3000, 16'h1800);
		`CHK(qPeakField, 16'h2060)
		for (int r = 0; r < 2; r++) begin
			@(posedge clk_sys);
			{timeSync, c1Result, c2Result} <= 6'h00;
			frameTick <= 1'b1;
			@(posedge clk_sys);
			frameTick <= 1'b0;
			tick(550);
			#1 `CHK(corrFlagOe, r == 1)
			tick(100);
			#1 `CHK(corrFlagOe, r == 1)
			tick(150);
		end
		wr(dapo_pkg::REG_CTRL, {12'h000, dapo_pkg::FMT_ROM_I2S});
		pair(16'h7000, 16'h7000, 2'b11);
		pair(16'h0000, 16'h0000);
		`CHK(qPeakField, 16'hE0E0)
		$display("concealment test done");
	endtask
	// mute ramp in progress
	task automatic t_mute();
		wr(dapo_pkg::REG_LEVEL, {14'h0000, dapo_pkg::CMD_MUTE});
		tick(20 * dapo_pkg::STEP_CYC);
		rd(dapo_pkg::REG_STATUS);
		`CHK(d[9], 1'b1)
		`CHK(d[7:0] < dapo_pkg::LVL_FULL, 1'b1)
		$display("mute test done");
	endtask
	// de-emphasis routed out, then internal
	task automatic t_deemph();
		wr(dapo_pkg::REG_CTRL, 16'h004E);
		preEmphasis <= 1'b1;
		tick(5);
		`CHK(sparePinFive, 1'b1)
		rd(dapo_pkg::REG_STATUS);
		`CHK(d[8], 1'b0)
		wr(dapo_pkg::REG_CTRL, 16'h000E);
		tick(5);
		`CHK(sparePinFive, 1'b0)
		rd(dapo_pkg::REG_STATUS);
		`CHK(d[8], 1'b1)
		$display("de-emphasis test done");
	endtask
	// counts and verdict
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		tick(8);
		nrst <= 1'b1;
		t_reset();
		t_flag();
		t_strobe();
		t_level();
		t_peak();
		t_conceal();
		t_mute();
		t_deemph();
		close_out();
	end
	// watchdog against a hang
	initial begin
		#(95000 * 50);
		err_total++;
		close_out();
	end
endmodule // tb
